// ===== codec_regs_pkg.sv
// package for the capture/mode control register bank
// assumes a 32-bit avalon-mm slave with word addressing by byte address
package codec_regs_pkg;
    // ==========================================================
    // register indices and byte addresses
    localparam logic [3:0] IDX_CAPTURE = 4'h6;
    localparam logic [3:0] IDX_MODE = 4'h7;
    localparam logic [3:0] IDX_IDENTITY = 4'h8;
    localparam logic [3:0] IDX_PENDING = 4'h9;
    localparam int ADDR_W = 6;
    localparam logic [5:0] ADDR_CAPTURE = {IDX_CAPTURE, 2'b00};
    localparam logic [5:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [5:0] ADDR_IDENTITY = {IDX_IDENTITY, 2'b00};
    localparam logic [5:0] ADDR_PENDING = {IDX_PENDING, 2'b00};
    // ==========================================================
    // field positions
    localparam int CAP_DITHER = 5;
    localparam int CAP_FRAMING = 4;
    localparam int CAP_MUTE_B = 3;
    localparam int CAP_MUTE_A = 2;
    localparam int CAP_HPF_OFF_B = 1;
    localparam int CAP_HPF_OFF_A = 0;
    localparam int MODE_LOOPBACK = 4;
    localparam int MODE_PAIRING = 3;
    localparam int MODE_HOLD = 2;
    localparam int MODE_HOST_SEL = 1;
    localparam int MODE_LOW_POWER = 0;
    localparam logic [7:0] CAP_MASK = 8'h3F;
    localparam logic [7:0] MODE_MASK = 8'h1F;
    // ==========================================================
    // reset values
    localparam logic [7:0] CAPTURE_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // ==========================================================
    // capture framing encodings
    localparam logic FRAMING_LEFT_JUST = 1'b0;
    localparam logic FRAMING_I2S = 1'b1;

    typedef struct packed {
        logic dither_16;
        logic framing_i2s;
        logic [1:0] capture_mute;
        logic [1:0] hpf_disable;
    } capture_ctrl_s;

    typedef struct packed {
        logic loopback;
        logic mute_output_pairing;
        logic host_register_mode_select;
        logic low_power_request;
    } mode_ctrl_s;
endpackage

// ===== codec_adc_mode_control_regs.sv
// register bank: capture control, global mode control and identity
// assumes an avalon-mm master on clk_in; the mute requests come from
// the output path on the same clock, so they are not synchronised
// Notes on behaviour
// - capture dither bit enables dither on 16-bit captured data.
// - capture framing bit: 0 left-justified (default), 1 I2S.
// - two capture mute bits mute channel A and B independently.
// - high-pass disable bits freeze the offset estimate, still subtracted.
// - mode loopback bit routes captured samples to the playback path.
// - pairing bit ANDs both channel mute indications onto both pins.
// - while the hold bit is set, writes are stored but applied together later.
// - host-mode select bit resets cleared; setting it enters register mode.
// - low-power bit resets set; host clears it to start operation.
// - register contents are kept unchanged in the low-power state.
// - identity register is read-only: type code 7:4, revision 3:0.
// - mute indication pins are active low.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
module codec_adc_mode_control_regs #(
    // arbitrary neutral identity values
    parameter logic [3:0] DEVICE_TYPE_CODE = 4'hA,
    parameter logic [3:0] SILICON_STEP_CODE = 4'h5
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [codec_regs_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic chan_a_mute_request_in,
    input wire logic chan_b_mute_request_in,
    output codec_regs_pkg::capture_ctrl_s capture_ctrl_out,
    output codec_regs_pkg::mode_ctrl_s mode_ctrl_out,
    output logic chan_a_mute_indication_n_out,
    output logic chan_b_mute_indication_n_out
);
    // ==========================================================
    // bus handshake: one wait cycle, answer on the second edge
    logic ack_q;
    logic access;
    logic wr_take;
    logic rd_take;
    logic [7:0] cap_shadow_q;
    logic [7:0] mode_shadow_q;
    logic [7:0] cap_live_q;
    logic [7:0] mode_live_q;
    logic [7:0] wr_byte;
    logic hold_now;
    logic hold_next;

    assign access = (avs_read_in | avs_write_in) & ~ack_q;
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign wr_take = avs_write_in & ack_q & avs_byteenable_in[0];
    assign rd_take = avs_read_in & ack_q;
    assign wr_byte = avs_writedata_in[7:0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    function automatic logic addr_is(input logic [codec_regs_pkg::ADDR_W-1:0] a,
                                     input logic [5:0] target);
        return a == target;
    endfunction

    // ==========================================================
    // shadow registers hold what software wrote; retained in low power
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cap_shadow_q <= codec_regs_pkg::CAPTURE_RESET;
            mode_shadow_q <= codec_regs_pkg::MODE_RESET;
        end else if (wr_take) begin
            if (addr_is(avs_address_in, codec_regs_pkg::ADDR_CAPTURE)) begin
                cap_shadow_q <= wr_byte & codec_regs_pkg::CAP_MASK;
            end
            if (addr_is(avs_address_in, codec_regs_pkg::ADDR_MODE)) begin
                mode_shadow_q <= wr_byte & codec_regs_pkg::MODE_MASK;
            end
            // identity and unmapped writes fall through untouched
        end
    end

    // ==========================================================
    // live copies drive the datapath; hold defers every change
    assign hold_now = mode_shadow_q[codec_regs_pkg::MODE_HOLD];
    assign hold_next = (wr_take && addr_is(avs_address_in, codec_regs_pkg::ADDR_MODE))
        ? wr_byte[codec_regs_pkg::MODE_HOLD] : hold_now;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cap_live_q <= codec_regs_pkg::CAPTURE_RESET;
            mode_live_q <= codec_regs_pkg::MODE_RESET;
        end else if (!hold_now && !hold_next) begin
            // tracks the shadow one cycle later; on release of hold all
            // pending fields land on the same edge
            cap_live_q <= cap_shadow_q;
            mode_live_q <= mode_shadow_q;
        end
    end

    // ==========================================================
    // control outputs to the converter path
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            capture_ctrl_out <= '0;
            mode_ctrl_out <= '0;
            mode_ctrl_out.low_power_request <= 1'b1;
        end else begin
            capture_ctrl_out.dither_16 <= cap_live_q[codec_regs_pkg::CAP_DITHER];
            capture_ctrl_out.framing_i2s <= cap_live_q[codec_regs_pkg::CAP_FRAMING];
            capture_ctrl_out.capture_mute <= {cap_live_q[codec_regs_pkg::CAP_MUTE_B],
                                              cap_live_q[codec_regs_pkg::CAP_MUTE_A]};
            capture_ctrl_out.hpf_disable <= {cap_live_q[codec_regs_pkg::CAP_HPF_OFF_B],
                                             cap_live_q[codec_regs_pkg::CAP_HPF_OFF_A]};
            mode_ctrl_out.loopback <= mode_live_q[codec_regs_pkg::MODE_LOOPBACK];
            mode_ctrl_out.mute_output_pairing <= mode_live_q[codec_regs_pkg::MODE_PAIRING];
            mode_ctrl_out.host_register_mode_select <= mode_live_q[codec_regs_pkg::MODE_HOST_SEL];
            mode_ctrl_out.low_power_request <= mode_live_q[codec_regs_pkg::MODE_LOW_POWER];
        end
    end

    // ==========================================================
    // mute indication pins, active low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            chan_a_mute_indication_n_out <= 1'b1;
            chan_b_mute_indication_n_out <= 1'b1;
        end else if (mode_live_q[codec_regs_pkg::MODE_PAIRING]) begin
            chan_a_mute_indication_n_out <= ~(chan_a_mute_request_in & chan_b_mute_request_in);
            chan_b_mute_indication_n_out <= ~(chan_a_mute_request_in & chan_b_mute_request_in);
        end else begin
            chan_a_mute_indication_n_out <= ~chan_a_mute_request_in;
            chan_b_mute_indication_n_out <= ~chan_b_mute_request_in;
        end
    end

    // ==========================================================
    // read data, captured on the wait cycle and held until the answer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_readdata_out <= codec_regs_pkg::UNMAPPED_DATA;
        end else if (avs_read_in && !ack_q) begin
            unique case (1'b1)
                addr_is(avs_address_in, codec_regs_pkg::ADDR_CAPTURE):
                    avs_readdata_out <= {24'h000000, cap_shadow_q};
                addr_is(avs_address_in, codec_regs_pkg::ADDR_MODE):
                    avs_readdata_out <= {24'h000000, mode_shadow_q};
                addr_is(avs_address_in, codec_regs_pkg::ADDR_IDENTITY):
                    avs_readdata_out <= {24'h000000, DEVICE_TYPE_CODE, SILICON_STEP_CODE};
                addr_is(avs_address_in, codec_regs_pkg::ADDR_PENDING):
                    // bit 0 set while a stored change has not been applied yet
                    avs_readdata_out <= {31'h00000000,
                        (cap_shadow_q != cap_live_q) || (mode_shadow_q != mode_live_q)};
                default:
                    avs_readdata_out <= codec_regs_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    logic unused_rd;
    assign unused_rd = rd_take;
endmodule

// ===== codec_adc_mode_control_regs_assertions.sv
// concurrent checks for the capture/mode register bank
// assumes binding to the bank's top module; one clock, sync reset
`timescale 1ns/1ns
module codec_regs_checker #(
    parameter logic [3:0] DEVICE_TYPE_CODE = 4'hA,
    parameter logic [3:0] SILICON_STEP_CODE = 4'h5
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic chan_a_mute_request_in,
    input wire logic chan_b_mute_request_in,
    input wire codec_regs_pkg::capture_ctrl_s capture_ctrl_out,
    input wire codec_regs_pkg::mode_ctrl_s mode_ctrl_out,
    input wire logic chan_a_mute_indication_n_out,
    input wire logic chan_b_mute_indication_n_out
);
    // ====================
    // checks
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic rd_ack = avs_read_in && !avs_waitrequest_out;
    // pins lag the request by one edge, the pairing bit out lags live by one too
    chk_mute_pin_a: assert property (!$past(rst_in) |-> chan_a_mute_indication_n_out ==
        !($past(chan_a_mute_request_in) && ($past(chan_b_mute_request_in) || !mode_ctrl_out.mute_output_pairing)))
        else $error("mute pin a wrong");
    chk_mute_pin_b: assert property (!$past(rst_in) |-> chan_b_mute_indication_n_out ==
        !($past(chan_b_mute_request_in) && ($past(chan_a_mute_request_in) || !mode_ctrl_out.mute_output_pairing)))
        else $error("mute pin b wrong");
    chk_reset_vals: assert property ($past(rst_in) |-> capture_ctrl_out == 6'h00 && mode_ctrl_out == 4'h1)
        else $error("reset values wrong");
    chk_cap_cause: assert property ($changed(capture_ctrl_out) |-> $past(avs_write_in, 3) || $past(avs_write_in, 4))
        else $error("capture outputs moved unasked");
    chk_mode_cause: assert property ($changed(mode_ctrl_out) |-> $past(avs_write_in, 3) || $past(avs_write_in, 4))
        else $error("mode outputs moved unasked");
    chk_id_read: assert property (rd_ack && avs_address_in == codec_regs_pkg::ADDR_IDENTITY |->
        avs_readdata_out == {24'h0, DEVICE_TYPE_CODE, SILICON_STEP_CODE}) else $error("identity read wrong");
    chk_unmapped_zero: assert property (rd_ack && !(avs_address_in[5:2] inside {[4'h6:4'h9]}) |->
        avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("waitrequest too long");
    cover property (rd_ack && avs_address_in == codec_regs_pkg::ADDR_IDENTITY);
    cover property (mode_ctrl_out.mute_output_pairing && chan_a_mute_request_in && chan_b_mute_request_in);
    cover property ($changed(capture_ctrl_out));
endmodule
bind codec_adc_mode_control_regs codec_regs_checker #(.DEVICE_TYPE_CODE(DEVICE_TYPE_CODE),
    .SILICON_STEP_CODE(SILICON_STEP_CODE)) checks (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .chan_a_mute_request_in(chan_a_mute_request_in), .chan_b_mute_request_in(chan_b_mute_request_in),
    .capture_ctrl_out(capture_ctrl_out), .mode_ctrl_out(mode_ctrl_out),
    .chan_a_mute_indication_n_out(chan_a_mute_indication_n_out),
    .chan_b_mute_indication_n_out(chan_b_mute_indication_n_out));

// ===== host_ctrl_model.sv
// host controller model: avalon-mm master for the register bank
// assumes callers wait for xfer to return before the next request
`timescale 1ns/1ns
module host_ctrl_model (
    input wire logic clk_in,
    input wire logic waitrequest_in,
    output logic [5:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] writedata_out,
    output logic [3:0] byteenable_out
);
    // ====================
    // bus cycles
    logic tmo = 1'b0;
    initial begin
        {address_out, read_out, write_out, writedata_out, byteenable_out} = '0;
    end
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        {read_out, write_out, address_out, writedata_out, byteenable_out} <= {!w, w, a, d, 4'hF};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (!waitrequest_in) break;
        end
        if (n == 20) tmo = 1'b1;
        // released lines show garbage, so a stale value never looks valid
        {read_out, write_out, address_out, writedata_out} <= {2'b00, ~a, ~d};
    endtask
endmodule

// ===== codec_adc_mode_control_regs_tb.sv
// self-checking bench for the capture/mode register bank
// assumes the host model drives the bus; mute requests come from here
`timescale 1ns/1ns
module codec_adc_mode_control_regs_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ma = 1'b0;
    logic mb = 1'b0;
    logic rd, wr, wq, na, nb;
    logic [5:0] adr;
    logic [31:0] wd, rdat;
    logic [3:0] be;
    codec_regs_pkg::capture_ctrl_s cap;
    codec_regs_pkg::mode_ctrl_s mode;
    logic [31:0] exp_q[$];
    logic [31:0] lfsr = 32'hBCBD923E;
    int error_cnt = 0;
    int compares = 0;
    always #4 clk_in = ~clk_in;
    host_ctrl_model host (.clk_in(clk_in), .waitrequest_in(wq), .address_out(adr), .read_out(rd),
        .write_out(wr), .writedata_out(wd), .byteenable_out(be));
    codec_adc_mode_control_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wq), .chan_a_mute_request_in(ma), .chan_b_mute_request_in(mb),
        .capture_ctrl_out(cap), .mode_ctrl_out(mode), .chan_a_mute_indication_n_out(na),
        .chan_b_mute_indication_n_out(nb));
    // ====================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // waits out shadow, live and output stages
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d});
        repeat (3) @(posedge clk_in);
    endtask
    task automatic get(input logic [5:0] a, input logic [7:0] want);
        exp_q.push_back({24'h0, want});
        host.xfer(1'b0, a, 32'h0);
    endtask
    always @(posedge clk_in) begin
        if (rd === 1'b1 && wq === 1'b0) begin
            check(rdat, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        summarize();
    end
    // ====================
    // scenarios
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check(32'(cap), 32'h0);
        check(32'(mode), 32'h1);
        get(codec_regs_pkg::ADDR_MODE, 8'h01);
        get(codec_regs_pkg::ADDR_IDENTITY, 8'hA5);
        get(6'h3C, 8'h00);
        put(codec_regs_pkg::ADDR_MODE, 8'h12);  // host clears low power
        check(32'(mode), 32'hA);
        $display("defaults done");
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            put(codec_regs_pkg::ADDR_CAPTURE, lfsr[7:0]);
            check(32'(cap), 32'(lfsr[5:0]));
            get(codec_regs_pkg::ADDR_CAPTURE, lfsr[7:0] & codec_regs_pkg::CAP_MASK);
        end
        put(codec_regs_pkg::ADDR_CAPTURE, 8'h3F);
        put(codec_regs_pkg::ADDR_IDENTITY, 8'h00);
        get(codec_regs_pkg::ADDR_IDENTITY, 8'hA5);
        check(32'(cap), 32'h3F);
        $display("capture done");
        put(codec_regs_pkg::ADDR_MODE, 8'h16);  // hold first
        put(codec_regs_pkg::ADDR_CAPTURE, 8'h15);
        put(codec_regs_pkg::ADDR_MODE, 8'h1E);
        check(32'(cap), 32'h3F);
        check(32'(mode), 32'hA);
        get(codec_regs_pkg::ADDR_CAPTURE, 8'h15);
        get(codec_regs_pkg::ADDR_PENDING, 8'h01);
        put(codec_regs_pkg::ADDR_MODE, 8'h1A);  // hold cleared last
        check(32'({cap, mode}), 32'h15E);
        get(codec_regs_pkg::ADDR_PENDING, 8'h00);
        $display("hold done");
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                ma <= m[0];
                mb <= m[1];
                repeat (2) @(posedge clk_in);
                check(32'({na, nb}), 32'({~(m[0] & (m[1] | p[0])), ~(m[1] & (m[0] | p[0]))}));
            end
            if (p == 0) put(codec_regs_pkg::ADDR_MODE, 8'h12);
        end
        $display("mute done");
        put(codec_regs_pkg::ADDR_MODE, 8'h03);
        check(32'({cap, mode}), 32'h153);
        get(codec_regs_pkg::ADDR_CAPTURE, 8'h15);
        repeat (2) @(posedge clk_in);
        $display("low power done");
        if (host.tmo) error_cnt++;
        summarize();
    end
endmodule
